/* File: uirq_top.sv */
// Interrupt mask, line status and DMA request logic of the UART
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "uirq_regs.svh"
module uirq_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`UIRQ_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cts_in,
  input wire logic rts_out_level,
  input wire logic xoff_received,
  input wire logic modem_change,
  input wire logic rx_char_load,
  input wire logic [3:0] rx_char_err,
  input wire logic rx_fifo_has_err,
  input wire logic rx_timeout,
  input wire logic [`UIRQ_CNT_W-1:0] rx_count,
  input wire logic [`UIRQ_CNT_W-1:0] tx_count,
  input wire logic tx_shift_empty,
  output logic irq,
  output logic sleep_en,
  output logic fifo_enable,
  output logic dma_mode,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset,
  output logic tx_dma_request_n,
  output logic rx_dma_request_n
);
  import uirq_pkg::*;

  uirq_state_t st_r;
  uirq_state_t st_nxt;

  logic fifo_on;
  uirq_dma_t dma_sel;
  logic [`UIRQ_CNT_W-1:0] rx_trig;
  logic [`UIRQ_CNT_W-1:0] tx_trig;
  logic rx_level_hit;
  logic tx_below;
  logic rx_ready_src;
  logic thr_empty_src;
  logic [7:0] src_vec;
  logic [7:0] lstat;
  logic setup;
  logic access;
  logic [7:0] pend_vec;

  assign fifo_on = st_r.fctl[`UIRQ_F_EN];
  assign dma_sel = (fifo_on && st_r.fctl[`UIRQ_F_DMA]) ? UIRQ_DMA1 : UIRQ_DMA0;

  always_comb
  begin
    case (st_r.fctl[`UIRQ_F_RXT_HI:`UIRQ_F_RXT_LO])
      2'b00: rx_trig = `UIRQ_RXT_0;
      2'b01: rx_trig = `UIRQ_RXT_1;
      2'b10: rx_trig = `UIRQ_RXT_2;
      default: rx_trig = `UIRQ_RXT_3;
    endcase
    // Codes 10 and 11 are undefined; fall back to the reset level
    case (st_r.fctl[`UIRQ_F_TXT_HI:`UIRQ_F_TXT_LO])
      2'b01: tx_trig = `UIRQ_TXT_1;
      default: tx_trig = `UIRQ_TXT_0;
    endcase
  end

  assign rx_level_hit = rx_count >= rx_trig;
  assign tx_below = tx_count < tx_trig;

  // Level sources: they follow the FIFO counts, nothing to clear
  always_comb
  begin
    if (fifo_on)
      rx_ready_src = rx_level_hit || rx_timeout;
    else
      rx_ready_src = rx_count != `UIRQ_CNT_ZERO;
    if (dma_sel == UIRQ_DMA1)
      thr_empty_src = tx_below;
    else
      thr_empty_src = tx_count == `UIRQ_CNT_ZERO;
  end

  // Source register: one bit per pending event, trigger state in bit 0
  assign src_vec = {st_r.cts_pend, st_r.rts_pend, st_r.xoff_pend,
                    1'b0, st_r.modem_pend, st_r.line_pend,
                    thr_empty_src, rx_ready_src};

  assign lstat = {rx_fifo_has_err,
                  (tx_count == `UIRQ_CNT_ZERO) && tx_shift_empty,
                  tx_count == `UIRQ_CNT_ZERO,
                  st_r.err,
                  rx_count != `UIRQ_CNT_ZERO};

  assign pend_vec = src_vec;

  assign setup = psel && !penable;
  assign access = psel && penable && st_r.pready;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cts_prev = cts_in;
    st_nxt.rts_prev = rts_out_level;
    st_nxt.rx_fifo_rst = 1'b0;
    st_nxt.tx_fifo_rst = 1'b0;

    // Zero wait states: answer is staged during the setup cycle
    st_nxt.pready = setup;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (setup)
    begin
      case (paddr)
        `UIRQ_OFF_MASK: st_nxt.prdata = {24'h00_0000, st_r.mask};
        `UIRQ_OFF_FCTL: st_nxt.prdata = {24'h00_0000, st_r.fctl};
        `UIRQ_OFF_SRC: st_nxt.prdata = {24'h00_0000, src_vec};
        `UIRQ_OFF_LSTAT: st_nxt.prdata = {24'h00_0000, lstat};
        default: st_nxt.pslverr = 1'b1;
      endcase
    end

    // Read side effects first, so a same-cycle event wins below
    if (access && !pwrite)
    begin
      if (paddr == `UIRQ_OFF_SRC)
      begin
        st_nxt.cts_pend = 1'b0;
        st_nxt.rts_pend = 1'b0;
        st_nxt.xoff_pend = 1'b0;
        st_nxt.modem_pend = 1'b0;
      end
      if (paddr == `UIRQ_OFF_LSTAT)
      begin
        st_nxt.line_pend = 1'b0;
        st_nxt.err = `UIRQ_LSTAT_ERR_RST;
      end
    end

    if (access && pwrite)
    begin
      case (paddr)
        `UIRQ_OFF_MASK: st_nxt.mask = pwdata[7:0];
        `UIRQ_OFF_FCTL:
        begin
          // Other bits only take when the enable bit is written as 1
          if (pwdata[`UIRQ_F_EN])
          begin
            st_nxt.fctl = pwdata[7:0];
            st_nxt.fctl[`UIRQ_F_RXRST] = 1'b0;
            st_nxt.fctl[`UIRQ_F_TXRST] = 1'b0;
            st_nxt.rx_fifo_rst = pwdata[`UIRQ_F_RXRST];
            st_nxt.tx_fifo_rst = pwdata[`UIRQ_F_TXRST];
          end
          else
            st_nxt.fctl[`UIRQ_F_EN] = 1'b0;
        end
        // Read-only or unmapped: no effect, error staged in setup for unmapped only
        default: ;
      endcase
    end

    // Sticky events; set beats a clear in the same cycle
    if (cts_in && !st_r.cts_prev)
      st_nxt.cts_pend = 1'b1;
    if (rts_out_level && !st_r.rts_prev)
      st_nxt.rts_pend = 1'b1;
    if (xoff_received)
      st_nxt.xoff_pend = 1'b1;
    if (modem_change)
      st_nxt.modem_pend = 1'b1;
    if (rx_char_load)
    begin
      st_nxt.line_pend = 1'b1;
      st_nxt.err = st_nxt.err | rx_char_err;
    end

    st_nxt.irq = |(pend_vec & st_r.mask);

    // Block mode request latch: set at trigger, held until empty
    if (rx_count == `UIRQ_CNT_ZERO)
      st_nxt.rx_blk = 1'b0;
    else if (rx_level_hit || rx_timeout)
      st_nxt.rx_blk = 1'b1;

    case (dma_sel)
      UIRQ_DMA0:
      begin
        st_nxt.tx_req_n = tx_count != `UIRQ_CNT_ZERO;
        st_nxt.rx_req_n = rx_count == `UIRQ_CNT_ZERO;
      end
      UIRQ_DMA1:
      begin
        // Full FIFO is the only state with no room for the DMA
        st_nxt.tx_req_n = tx_count >= `UIRQ_DEPTH;
        st_nxt.rx_req_n = !(st_r.rx_blk || rx_level_hit);
      end
      default:
      begin
        st_nxt.tx_req_n = 1'b1;
        st_nxt.rx_req_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.mask <= `UIRQ_MASK_RST;
      st_r.fctl <= `UIRQ_FCTL_RST;
      st_r.tx_req_n <= 1'b1;
      st_r.rx_req_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign irq = st_r.irq;
  assign sleep_en = st_r.mask[`UIRQ_M_SLEEP];
  assign fifo_enable = st_r.fctl[`UIRQ_F_EN];
  assign dma_mode = st_r.fctl[`UIRQ_F_DMA];
  assign rx_fifo_reset = st_r.rx_fifo_rst;
  assign tx_fifo_reset = st_r.tx_fifo_rst;
  assign tx_dma_request_n = st_r.tx_req_n;
  assign rx_dma_request_n = st_r.rx_req_n;
endmodule

/* File: uirq_regs.svh */
// Register map, field positions and levels for the UART interrupt block
// Summary of operation
// - Mask bit 7 set: interrupt on each CTS rise from 0 to 1.
// - Mask bit 6 set: interrupt on each RTS rise from 0 to 1.
// - Mask bit 5 enables the received Xoff character interrupt.
// - Mask bit 4 enables sleep mode; it resets to disabled.
// - Mask bit 3 gates the modem status change interrupt.
// - Mask bit 2 gates line status interrupt raised on each received character.
// - Mask bit 1 gates transmitter-empty interrupt while holding register is empty.
// - Mask bit 0 gates receiver-ready interrupt; all mask bits reset to 0.
// - FIFO mode: receive interrupt while occupancy at or above trigger level.
// - Source register shows trigger condition; clears with interrupt below level.
// - Data-ready sets when a character enters FIFO, clears when FIFO empty.
// - Line status bits 1 to 4 report receive error kinds.
// - Line status bit 5 reads 1 when transmit FIFO is empty.
// - Line status bit 6 is 1 when transmit FIFO and shifter empty.
// - Line status bit 7 flags an error among data held in receive FIFO.
// - DMA mode 0: transmit request low while holding register has room.
// - DMA mode 0: receive request low while a character is held.
// - DMA mode 1: transmit interrupt while FIFO below transmit trigger level.
// - DMA mode 1: receive interrupt at trigger; FIFO keeps filling until full.
// - DMA mode 1: receive request stays low while fill above trigger level.
// - Receive trigger codes 00,01,10,11 select 8,16,24,28 bytes.
// - Transmit trigger codes 00 and 01 select 16 and 8 bytes.
`ifndef UIRQ_REGS_SVH
`define UIRQ_REGS_SVH

`define UIRQ_ADDR_W 12
`define UIRQ_OFF_MASK 12'h000
`define UIRQ_OFF_FCTL 12'h004
`define UIRQ_OFF_SRC 12'h008
`define UIRQ_OFF_LSTAT 12'h00c

`define UIRQ_MASK_RST 8'h00
`define UIRQ_FCTL_RST 8'h00
`define UIRQ_LSTAT_ERR_RST 4'h0

// Mask register bits
`define UIRQ_M_RX_DMA_REQUEST_N 0
`define UIRQ_M_THRE 1
`define UIRQ_M_LINE 2
`define UIRQ_M_MODEM 3
`define UIRQ_M_SLEEP 4
`define UIRQ_M_XOFF 5
`define UIRQ_M_RTS 6
`define UIRQ_M_CTS 7

// FIFO control bits
`define UIRQ_F_EN 0
`define UIRQ_F_RXRST 1
`define UIRQ_F_TXRST 2
`define UIRQ_F_DMA 3
`define UIRQ_F_TXT_LO 4
`define UIRQ_F_TXT_HI 5
`define UIRQ_F_RXT_LO 6
`define UIRQ_F_RXT_HI 7

// Line status bits
`define UIRQ_L_DR 0
`define UIRQ_L_ERR_LO 1
`define UIRQ_L_ERR_HI 4
`define UIRQ_L_TXFE 5
`define UIRQ_L_TEMT 6
`define UIRQ_L_FERR 7

`define UIRQ_CNT_W 6
`define UIRQ_DEPTH 6'd32
`define UIRQ_RXT_0 6'd8
`define UIRQ_RXT_1 6'd16
`define UIRQ_RXT_2 6'd24
`define UIRQ_RXT_3 6'd28
`define UIRQ_TXT_0 6'd16
`define UIRQ_TXT_1 6'd8
`define UIRQ_CNT_ZERO 6'd0

`endif

/* File: uirq_pkg.sv */
// Types shared by the UART interrupt block
package uirq_pkg;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] fctl;
    logic [3:0] err;
    logic line_pend;
    logic modem_pend;
    logic xoff_pend;
    logic rts_pend;
    logic cts_pend;
    logic cts_prev;
    logic rts_prev;
    logic rx_blk;
    logic rx_fifo_rst;
    logic tx_fifo_rst;
    logic irq;
    logic tx_req_n;
    logic rx_req_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } uirq_state_t;

  typedef enum logic [1:0] {
    UIRQ_DMA0 = 2'b01,
    UIRQ_DMA1 = 2'b10
  } uirq_dma_t;

endpackage

/* File: uirq_host.sv */
// Host model: APB master on the register bus
`timescale 1ns/100ps
module uirq_host
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic slverr_q,
  output logic to
);
  initial {psel, penable, pwrite, paddr, pwdata, to, slverr_q} = '0;
  // Request held until pready seen high at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 50);
    to = !pready;
    q = prdata;
    slverr_q = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
endmodule

/* File: uirq_top_sva.sv */
// Port assertions of the interrupt block
`timescale 1ns/100ps
module uirq_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic cts_in,
  input wire logic rts_out_level,
  input wire logic [5:0] rx_count,
  input wire logic [5:0] tx_count,
  input wire logic fifo_enable,
  input wire logic dma_mode,
  input wire logic irq,
  input wire logic sleep_en,
  input wire logic tx_dma_request_n,
  input wire logic rx_dma_request_n
);
  logic [7:0] m_r;
  logic wr;
  assign wr = psel && penable && pready && pwrite && paddr == 12'h000;
  // Mask mirror so irq can be tied to its cause
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      m_r <= 8'h00;
    else if (wr)
      m_r <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_sleep_bit: assert property (sleep_en == m_r[4])
    else $error("sleep enable differs from mask");
  chk_cts_irq: assert property ($rose(cts_in) && m_r[7] |-> ##2 irq)
    else $error("cts rise gave no irq");
  chk_rts_irq: assert property
    ($rose(rts_out_level) && m_r[6] |-> ##2 irq)
    else $error("rts rise gave no irq");
  chk_rx_level: assert property
    ((fifo_enable && m_r[0] && rx_count >= 6'd28)[*3] |-> irq)
    else $error("rx level gave no irq");
  chk_masked_quiet: assert property ((m_r == 8'h00)[*2] |-> !irq)
    else $error("irq with all masked");
  chk_tx_req_m0: assert property
    (!dma_mode && tx_count == 6'd0 |=> !tx_dma_request_n)
    else $error("tx request high with room");
  chk_rx_req_m0: assert property
    (!dma_mode && rx_count != 6'd0 |=> !rx_dma_request_n)
    else $error("rx request high with data");
  chk_rx_req_m1: assert property
    (dma_mode && rx_count > 6'd28 |=> !rx_dma_request_n)
    else $error("rx request high above trigger");
  cover property ($rose(irq));
  cover property (dma_mode && !rx_dma_request_n);
  cover property ($fell(tx_dma_request_n));
endmodule

/* File: testbench.sv */
// Self-checking testbench of the interrupt block
`timescale 1ns/100ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, to;
  logic sleep_en, fifo_enable, dma_mode, rx_char_load, tx_shift_empty;
  logic tx_dma_request_n, rx_dma_request_n;
  logic modem_change, rx_fifo_has_err, slverr_q;
  logic [5:0] trg [4] = '{6'd8, 6'd16, 6'd24, 6'd28};
  logic [2:0] evs;
  logic [3:0] rx_char_err;
  logic [5:0] rx_count, tx_count;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_errors, check_count;
  uirq_host u_uirq_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .slverr_q, .to);
  uirq_top u_uirq_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cts_in(evs[2]),
    .rts_out_level(evs[1]), .xoff_received(evs[0]), .modem_change,
    .rx_char_load, .rx_char_err, .rx_fifo_has_err, .rx_timeout(1'b0),
    .rx_count, .tx_count, .tx_shift_empty, .irq, .sleep_en, .fifo_enable,
    .dma_mode, .rx_fifo_reset(), .tx_fifo_reset(), .tx_dma_request_n,
    .rx_dma_request_n);
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_uirq_host.xfer(w, a, d, q);
    if (to)
    begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task t_reset;
    rw(0, 12'h000, 0);
    chk("mask", q, 32'h0);
    chk("slverr", slverr_q, 0);
    rw(0, 12'h00c, 0);
    chk("lstat", q, 32'h60);
    tx_shift_empty <= 0;
    rw(0, 12'h010, 0);
    chk("unmapped", q, 32'h0);
    chk("slverr", slverr_q, 1);
    rw(1, 12'h010, 32'hff);
    chk("slverr", slverr_q, 1);
    step(1);
    chk("slverr", pslverr, 0);
    rw(0, 12'h00c, 0);
    chk("lstat", q, 32'h20);
    rw(1, 12'h000, 32'h10);
    step(1);
    chk("sleep", sleep_en, 1);
    $display("t_reset done");
  endtask
  task t_events;
    for (int i = 0; i <= 3; i++)
    begin
      rw(1, 12'h000, i < 3 ? 32'h80 >> i : 0);
      evs <= i < 3 ? 3'h4 >> i : 3'h7;
      step(1);
      evs <= 3'h0;
      step(2);
      chk("irq", irq, i < 3);
      rw(0, 12'h008, 0);
      chk("src", q & 32'he0, i < 3 ? 32'h80 >> i : 32'he0);
    end
    rw(1, 12'h000, 32'h08);
    modem_change <= 1;
    step(1);
    modem_change <= 0;
    step(2);
    chk("irq", irq, 1);
    rw(0, 12'h008, 0);
    chk("src", q & 32'h08, 32'h08);
    step(2);
    chk("irq", irq, 0);
    $display("t_events done");
  endtask
  task t_fifo;
    rw(1, 12'h004, 32'h41);
    rw(1, 12'h000, 32'h01);
    for (int i = 15; i <= 17; i++)
    begin
      rx_count <= i[5:0] == 6'd17 ? 6'd15 : i[5:0];
      step(3);
      chk("irq", irq, i == 16);
      rw(0, 12'h008, 0);
      chk("src", q[0], i == 16);
    end
    for (int c = 0; c < 4; c++)
    begin
      rw(1, 12'h004, {24'h00_0000, c[1:0], 6'h01});
      rx_count <= trg[c] - 6'd1;
      step(3);
      chk("irq", irq, 0);
      rx_count <= trg[c];
      step(3);
      chk("irq", irq, 1);
    end
    rw(1, 12'h000, 32'h04);
    rx_char_err <= 4'h5;
    rx_char_load <= 1;
    rx_fifo_has_err <= 1;
    step(1);
    rx_char_load <= 0;
    step(2);
    chk("irq", irq, 1);
    rw(1, 12'h000, 32'h00);
    rw(0, 12'h00c, 0);
    chk("lstat", q, 32'hab);
    rx_count <= 0;
    rx_fifo_has_err <= 0;
    step(3);
    rw(0, 12'h00c, 0);
    chk("lstat", q, 32'h20);
    $display("t_fifo done");
  endtask
  task t_dma;
    rw(1, 12'h000, 32'h02);
    step(2);
    chk("req", {tx_dma_request_n, rx_dma_request_n}, 2'b01);
    chk("irq", irq, 1);
    {tx_count, rx_count} <= {6'd1, 6'd1};
    step(3);
    chk("req", {tx_dma_request_n, rx_dma_request_n}, 2'b10);
    chk("irq", irq, 0);
    rw(1, 12'h004, 32'h19);
    rw(1, 12'h000, 32'h02);
    {tx_count, rx_count} <= {6'd8, 6'd9};
    step(3);
    chk("irq", irq, 0);
    chk("rxreq", rx_dma_request_n, 0);
    tx_count <= 6'd7;
    step(3);
    chk("irq", irq, 1);
    tx_count <= 6'd32;
    step(3);
    chk("txreq", tx_dma_request_n, 1);
    $display("t_dma done");
  endtask
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    {presetn, evs, rx_char_load, rx_char_err, rx_count, tx_count} = '0;
    {modem_change, rx_fifo_has_err} = '0;
    tx_shift_empty = 1;
    n_errors = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_events;
    t_fifo;
    t_dma;
    tally_and_finish;
  end
endmodule
bind uirq_top uirq_chk u_uirq_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .paddr, .pwdata, .cts_in, .rts_out_level, .rx_count, .tx_count,
  .fifo_enable, .dma_mode, .irq, .sleep_en, .tx_dma_request_n,
  .rx_dma_request_n);
